// ### mrr_ctrl_model.sv
// Controller model that drives the memory pins of the read port.
`timescale 1ns/1ps
module mrr_ctrl_model
	import mrr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic                  clk_sys,
	output logic                       mem_clk,
	output logic                       chip_sel_b,
	output logic                       write_sel,
	output logic                       out_en,
	output logic      [ADDR_W-1:0]     addr,
	output logic      [MRR_DATA_W-1:0] dq_drv,
	input  wire logic [MRR_DATA_W-1:0] dq_out,
	input  wire logic [MRR_DATA_W-1:0] dq_oe_b
);
	initial begin
		mem_clk = 1'h0;
		chip_sel_b = 1'h1;
		write_sel = 1'h0;
		out_en = 1'h0;
		addr = '0;
		dq_drv = '0;
	end

	// The high phase is long so the synchronised drive is surely seen.
	task automatic access(
		input  logic                  cs_b,
		input  logic                  we,
		input  logic [ADDR_W-1:0]     a,
		input  logic [MRR_DATA_W-1:0] d,
		input  int                    on_at,
		input  int                    off_at,
		output logic [MRR_DATA_W-1:0] rd,
		output logic [MRR_DATA_W-1:0] oe_mid,
		output logic [MRR_DATA_W-1:0] oe_end,
		output logic [MRR_DATA_W-1:0] oe_low
	);
		@(negedge clk_sys);
		chip_sel_b = cs_b;
		write_sel = we;
		addr = a;
		dq_drv = d;
		mem_clk = 1'h1;
		for (int i = 0; i < 18; i++) begin
			if (i == 12) begin
				rd = dq_out;
				oe_mid = dq_oe_b;
			end
			out_en = (i >= on_at) && (i < off_at);
			@(negedge clk_sys);
		end
		oe_end = dq_oe_b;
		mem_clk = 1'h0;
		// Hold time is over, so stale values must not look valid.
		addr = ~addr;
		dq_drv = ~dq_drv;
		repeat (6) @(negedge clk_sys);
		oe_low = dq_oe_b;
	endtask
endmodule

// ### mrr_ecc_fix.sv
// Syndrome decoder that corrects one flipped bit of a stored codeword.
`timescale 1ns/1ps
module mrr_ecc_fix
	import mrr_pkg::*;
(
	input  wire logic [MRR_CODE_W-1:0] code,
	output logic      [MRR_DATA_W-1:0] data
);
	logic [MRR_CODE_W-1:0] fixed;
	logic [MRR_CHK_W-1:0]  syn;
	int                    k;

	always_comb begin
		syn = '0;
		fixed = code;
		data = '0;
		k = 0;
		for (int p = 1; p <= MRR_CODE_W; p++) begin
			if (code[p-1]) begin
				syn = syn ^ MRR_CHK_W'(p);
			end
		end
		// A syndrome beyond the codeword cannot name a bit; leave it alone.
		for (int p = 1; p <= MRR_CODE_W; p++) begin
			if (syn == MRR_CHK_W'(p)) begin
				fixed[p-1] = ~code[p-1];
			end
		end
		for (int p = 1; p <= MRR_CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				data[k] = fixed[p-1];
				k++;
			end
		end
	end
endmodule

// ### mrr_pkg.sv
// Shared constants and the check-bit function for the memory random read port.
package mrr_pkg;
	localparam int         MRR_ADDR_W  = 21;
	localparam int         MRR_DATA_W  = 16;
	localparam int         MRR_CHK_W   = 5;
	localparam int         MRR_CODE_W  = MRR_DATA_W + MRR_CHK_W;
	localparam int         MRR_BYTE_W  = 8;
	localparam logic [0:0] MRR_RST_LOW = 1'h0;
	localparam logic [0:0] MRR_RST_HIGH = 1'h1;

	// Hamming code: check bits sit at power-of-two positions 1, 2, 4, 8, 16.
	function automatic logic [MRR_CODE_W-1:0] mrr_encode(
		input logic [MRR_DATA_W-1:0] d
	);
		logic [MRR_CODE_W-1:0] c;
		int                    k;
		c = '0;
		k = 0;
		for (int p = 1; p <= MRR_CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				c[p-1] = d[k];
				k++;
			end
		end
		for (int i = 0; i < MRR_CHK_W; i++) begin
			for (int p = 1; p <= MRR_CODE_W; p++) begin
				if (((p >> i) & 1) == 1 && p != (1 << i)) begin
					c[(1<<i)-1] = c[(1<<i)-1] ^ c[p-1];
				end
			end
		end
		return c;
	endfunction
endpackage

// ### mrr_read_port.sv
// Synchronous magnetic memory read port with single-bit correction.
// Functional notes
// R1 - Word address and write select are sampled on each rising memory clock edge.
// R2 - A read of the sampled address starts after that edge.
// R3 - Each read word is checked and single-bit errors corrected before delivery.
// R4 - With write select sampled low, the corrected word goes to the drivers.
// R5 - Data pins drive during a read only while output enable is high.
// R6 - Output enable is a live level, never latched on the clock edge.
// R7 - Data pins float whenever the memory clock is low.
// R8 - Dropping output enable returns the data pins to high impedance.
// R9 - Controller waits the startup time after power-up before any access.
// R10 - Write select sampled high starts a write; data pins stay floating.
// R11 - Chip select sampled high disables the device: no access, pins float.
// R12 - Correction alters only the delivered word, never the stored cells.
// R13 - Byte-width configuration high uses only the lower eight data pins.
// R14 - Controller spaces reads by at least the minimum read cycle time.
`timescale 1ns/1ps
module mrr_read_port
	import mrr_pkg::*;
#(
	parameter int ADDR_W = MRR_ADDR_W
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_b,
	input  wire logic                  mem_clk,
	input  wire logic                  chip_sel_b,
	input  wire logic                  write_sel,
	input  wire logic                  out_en,
	input  wire logic                  byte_width_config,
	input  wire logic [ADDR_W-1:0]     addr,
	input  wire logic [MRR_DATA_W-1:0] dq_in,
	output logic      [MRR_DATA_W-1:0] dq_out,
	output logic      [MRR_DATA_W-1:0] dq_oe_b
);
	localparam int WORD_W = ADDR_W - 1;

	typedef struct packed {
		logic                  clk1, clk2, clk3;
		logic                  ce1, ce2;
		logic                  we1, we2;
		logic                  oe1, oe2;
		logic                  bw1, bw2;
		logic [ADDR_W-1:0]     addr1, addr2;
		logic [MRR_DATA_W-1:0] din1, din2;
		logic                  ph1, ph1_we;
		logic                  ph2, ph2_we;
		logic [WORD_W-1:0]     word;
		logic                  bsel;
		logic                  bmode;
		logic [MRR_DATA_W-1:0] wdata;
		logic [MRR_CODE_W-1:0] code;
		logic                  valid;
		logic [MRR_DATA_W-1:0] data;
		logic [MRR_DATA_W-1:0] dq_out;
		logic [MRR_DATA_W-1:0] dq_oe_b;
	} mrr_state_t;

	mrr_state_t            st;
	mrr_state_t            next_st;
	logic [MRR_CODE_W-1:0] mem [2**WORD_W];
	logic [MRR_DATA_W-1:0] fixed_data;
	logic [MRR_DATA_W-1:0] merged;
	logic                  clk_rise;
	logic                  mem_we;

	mrr_ecc_fix i_mrr_ecc_fix (
		.code (st.code),
		.data (fixed_data)
	);

	assign clk_rise = st.clk2 & ~st.clk3;
	assign mem_we   = st.ph2 & st.ph2_we;

	always_comb begin
		merged = st.wdata;
		if (st.bmode) begin
			merged = st.bsel ? {st.wdata[7:0], fixed_data[7:0]}
			                 : {fixed_data[15:8], st.wdata[7:0]};
		end
	end

	always_comb begin
		next_st = st;
		next_st.clk1  = mem_clk;
		next_st.clk2  = st.clk1;
		next_st.clk3  = st.clk2;
		next_st.ce1   = chip_sel_b;
		next_st.ce2   = st.ce1;
		next_st.we1   = write_sel;
		next_st.we2   = st.we1;
		next_st.oe1   = out_en;
		next_st.oe2   = st.oe1;
		next_st.bw1   = byte_width_config;
		next_st.bw2   = st.bw1;
		next_st.addr1 = addr;
		next_st.addr2 = st.addr1;
		next_st.din1  = dq_in;
		next_st.din2  = st.din1;
		next_st.ph1   = 1'h0;
		next_st.ph2   = st.ph1;
		next_st.ph2_we = st.ph1_we;
		if (clk_rise) begin
			// Each new access retires the previous read word.
			next_st.valid = 1'h0;
			if (!st.ce2) begin // R11
				next_st.ph1    = 1'h1; // R1 R2
				next_st.ph1_we = st.we2; // R10
				next_st.bmode  = st.bw2;
				next_st.wdata  = st.din2;
				if (st.bw2) begin
					next_st.word = st.addr2[ADDR_W-1:1];
					next_st.bsel = st.addr2[0];
				end else begin
					next_st.word = st.addr2[WORD_W-1:0];
					next_st.bsel = 1'h0;
				end
			end
		end
		if (st.ph1) begin
			next_st.code = mem[st.word]; // R2
		end
		// A write first reads the cell so byte writes can merge.
		if (st.ph2) begin
			next_st.data  = fixed_data; // R3
			next_st.valid = ~st.ph2_we; // R4 R10
		end
		// Select byte lane in byte mode.
		if (st.bmode && st.bsel) begin
			next_st.dq_out = {8'h00, st.data[15:8]};
		end else begin
			next_st.dq_out = st.data;
		end
		// Enable is a live product of level inputs, so it tracks them.
		for (int i = 0; i < MRR_DATA_W; i++) begin
			next_st.dq_oe_b[i] = ~(st.valid & st.oe2 & st.clk2 // R5 R6 R7 R8
				& ~(st.bw2 & (i >= MRR_BYTE_W))); // R13
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.ce1 <= MRR_RST_HIGH;
			st.ce2 <= MRR_RST_HIGH;
			st.dq_oe_b <= '1;
		end else begin
			st <= next_st;
		end
	end

	// Cells change only on a write; correction never writes back.
	// A plain always lets a test plant a flipped bit in a stored word.
	always @(posedge clk_sys) begin
		if (mem_we) begin
			mem[st.word] <= mrr_encode(merged); // R12
		end
	end

	assign dq_out  = st.dq_out;
	assign dq_oe_b = st.dq_oe_b;

	sequence s_read_start;
		clk_rise && !st.ce2 && !st.we2;
	endsequence

	sequence s_read_done;
		st.ph1 ##1 st.ph2 ##1 st.valid;
	endsequence

	property p_sample;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_rise && !st.ce2 && !st.bw2 |=> st.word == $past(st.addr2[WORD_W-1:0]);
	endproperty
	a_sample: assert property (p_sample) else $error("address not sampled"); // R1

	property p_read_flow;
		@(posedge clk_sys) disable iff (!rst_b)
		s_read_start |=> s_read_done;
	endproperty
	a_read_flow: assert property (p_read_flow) else $error("read not delivered"); // R2 R4

	property p_fix_delivered;
		@(posedge clk_sys) disable iff (!rst_b)
		st.ph2 |=> st.data == $past(fixed_data) && st.code == $past(st.code);
	endproperty
	a_fix_delivered: assert property (p_fix_delivered) else $error("word not corrected"); // R3

	property p_drive_cause;
		@(posedge clk_sys) disable iff (!rst_b)
		!st.dq_oe_b[0] |-> $past(st.valid) && $past(st.oe2) && $past(st.clk2);
	endproperty
	a_drive_cause: assert property (p_drive_cause) else $error("drive without cause"); // R5

	property p_oe_live;
		@(posedge clk_sys) disable iff (!rst_b)
		st.valid && st.oe2 && st.clk2 |=> !st.dq_oe_b[0];
	endproperty
	a_oe_live: assert property (p_oe_live) else $error("enable level ignored"); // R6

	property p_clk_low;
		@(posedge clk_sys) disable iff (!rst_b)
		!st.clk2 |=> &st.dq_oe_b;
	endproperty
	a_clk_low: assert property (p_clk_low) else $error("driving with clock low"); // R7

	property p_oe_low;
		@(posedge clk_sys) disable iff (!rst_b)
		!st.oe2 |=> &st.dq_oe_b;
	endproperty
	a_oe_low: assert property (p_oe_low) else $error("driving with enable low"); // R8

	property p_write_float;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_rise && !st.ce2 && st.we2 |=> ##2 !st.valid ##1 &st.dq_oe_b;
	endproperty
	a_write_float: assert property (p_write_float) else $error("write drove pins"); // R10

	property p_disable;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_rise && st.ce2 |=> !st.ph1 ##1 !st.ph2 && !mem_we;
	endproperty
	a_disable: assert property (p_disable) else $error("access while disabled"); // R11

	property p_no_writeback;
		@(posedge clk_sys) disable iff (!rst_b)
		mem_we |-> $past(st.ph1 && st.ph1_we) && $past(clk_rise, 2);
	endproperty
	a_no_writeback: assert property (p_no_writeback) else $error("cell written on read"); // R12

	property p_byte_lanes;
		@(posedge clk_sys) disable iff (!rst_b)
		st.bw2 |=> &st.dq_oe_b[15:8];
	endproperty
	a_byte_lanes: assert property (p_byte_lanes) else $error("upper lanes driven"); // R13
endmodule

// ### test_mrr_read_port.sv
// Self-checking bench for the memory random read port.
`timescale 1ns/1ps
module test_mrr_read_port
	import mrr_pkg::*;
;
	localparam int AW = 8;
	logic                  clk_sys = 1'h0;
	logic                  rst_b = 1'h0;
	logic                  byte_width_config = 1'h0;
	logic                  mem_clk, chip_sel_b, write_sel, out_en;
	logic [AW-1:0]         addr;
	logic [MRR_DATA_W-1:0] dq_drv, dq_pin, dq_out, dq_oe_b;
	logic [MRR_DATA_W-1:0] rd, om, oe, ol;
	logic [MRR_CODE_W-1:0] raw;
	int                    failures = 0;
	int                    n_compared = 0;

	always #10 clk_sys = ~clk_sys;
	assign dq_pin = (dq_out & ~dq_oe_b) | (dq_drv & dq_oe_b);

	mrr_read_port #(.ADDR_W(AW)) i_mrr_read_port (.clk_sys(clk_sys),
		.rst_b(rst_b), .mem_clk(mem_clk), .chip_sel_b(chip_sel_b),
		.write_sel(write_sel), .out_en(out_en),
		.byte_width_config(byte_width_config), .addr(addr),
		.dq_in(dq_pin), .dq_out(dq_out), .dq_oe_b(dq_oe_b));
	mrr_ctrl_model #(.ADDR_W(AW)) i_mrr_ctrl_model (.clk_sys(clk_sys),
		.mem_clk(mem_clk), .chip_sel_b(chip_sel_b), .write_sel(write_sel),
		.out_en(out_en), .addr(addr), .dq_drv(dq_drv), .dq_out(dq_out),
		.dq_oe_b(dq_oe_b));

	task automatic chk(input logic [MRR_DATA_W-1:0] g, e);
		n_compared++;
		if (g !== e) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
			failures++;
		end
	endtask

	task automatic chk_code(input logic [MRR_CODE_W-1:0] g, e);
		n_compared++;
		if (g !== e) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
			failures++;
		end
	endtask

	task automatic end_sim();
		$display("failures=%0d n_compared=%0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic acc(input logic c, w, input logic [AW-1:0] a,
		input logic [MRR_DATA_W-1:0] d, input int on_at, off_at);
		i_mrr_ctrl_model.access(c, w, a, d, on_at, off_at, rd, om, oe, ol);
	endtask

	task automatic sc_write_read();
		acc(1'h0, 1'h1, 8'h05, 16'h1234, 0, 18);
		chk(om, 16'hffff);
		acc(1'h0, 1'h1, 8'h06, 16'hbeef, 0, 18);
		acc(1'h0, 1'h0, 8'h05, 16'h0000, 0, 18);
		chk(rd, 16'h1234);
		chk(om, 16'h0000);
		chk(oe, 16'h0000);
		chk(ol, 16'hffff);
		acc(1'h0, 1'h0, 8'h06, 16'h0000, 0, 18);
		chk(rd, 16'hbeef);
	endtask

	task automatic sc_out_en();
		acc(1'h0, 1'h0, 8'h05, 16'h0000, 18, 18);
		chk(om, 16'hffff);
		acc(1'h0, 1'h0, 8'h05, 16'h0000, 6, 18);
		chk(om, 16'h0000);
		chk(rd, 16'h1234);
		acc(1'h0, 1'h0, 8'h05, 16'h0000, 0, 12);
		chk(om, 16'h0000);
		chk(oe, 16'hffff);
	endtask

	task automatic sc_ecc();
		raw = i_mrr_read_port.mem[5];
		raw[6] = ~raw[6];
		i_mrr_read_port.mem[5] = raw;
		acc(1'h0, 1'h0, 8'h05, 16'h0000, 0, 18);
		chk(rd, 16'h1234);
		chk_code(i_mrr_read_port.mem[5], raw);
	endtask

	task automatic sc_disable();
		acc(1'h1, 1'h1, 8'h05, 16'h5555, 0, 18);
		chk(om, 16'hffff);
		acc(1'h0, 1'h0, 8'h05, 16'h0000, 0, 18);
		chk(rd, 16'h1234);
	endtask

	task automatic sc_byte();
		@(negedge clk_sys);
		byte_width_config = 1'h1;
		repeat (4) @(negedge clk_sys);
		acc(1'h0, 1'h1, 8'h0d, 16'h00ab, 0, 18);
		acc(1'h0, 1'h0, 8'h0c, 16'h0000, 0, 18);
		chk({8'h00, rd[7:0]}, 16'h00ef);
		chk(om, 16'hff00);
		acc(1'h0, 1'h0, 8'h0d, 16'h0000, 0, 18);
		chk({8'h00, rd[7:0]}, 16'h00ab);
	endtask

	initial begin
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_b = 1'h1;
		repeat (4) @(negedge clk_sys);
		sc_write_read();
		sc_out_en();
		sc_ecc();
		sc_disable();
		sc_byte();
		end_sim();
	end

	// A hang is cut short here and counted as a mismatch.
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		end_sim();
	end
endmodule
